// ---- verilog/fbs_pkg.sv ----
// package of constants and types for the flow-through burst sram port
// assumes a single rising-edge clock domain
package fbs_pkg;
  localparam int FBS_ADDR_W = 17;
  localparam int FBS_DATA_W = 32;
  localparam int FBS_LANES = 4;
  localparam int FBS_LANE_W = 8;
  localparam int FBS_BUS_W = 36;
  localparam int FBS_BURST_W = 2;
  localparam logic [1:0] FBS_BURST_LAST = 2'h3;
  localparam logic FBS_MODE_INTERLEAVED = 1'b1;
  localparam logic FBS_MODE_DEFAULT = 1'b1;
  typedef enum logic [2:0] {
    FBS_IDLE  = 3'h1,
    FBS_READ  = 3'h2,
    FBS_WRITE = 3'h4
  } fbs_state_t;
endpackage

// ---- verilog/fbs_burst_if.sv ----
// interface between the port control and the burst address counter
// assumes both ends share sys_clk_in
`timescale 1ns/100ps
`default_nettype none
interface fbs_burst_if;
  import fbs_pkg::*;
  logic load;
  logic step;
  logic mode;
  logic [FBS_BURST_W-1:0] start;
  logic [FBS_BURST_W-1:0] addr_lo;
  modport ctrl (output load, output step, output mode, output start, input addr_lo);
  modport ctr (input load, input step, input mode, input start, output addr_lo);
endinterface
`default_nettype wire

// ---- verilog/fbs_burst_ctr.sv ----
// two-bit burst address counter, linear or interleaved
// assumes load and step already qualified by the clock qualifier
`timescale 1ns/100ps
`default_nettype none
module fbs_burst_ctr
  import fbs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  fbs_burst_if.ctr bus
);
  logic [FBS_BURST_W-1:0] base_q;
  logic [FBS_BURST_W-1:0] cnt_q;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      base_q <= 2'h0;
      cnt_q <= 2'h0;
    end else if (bus.load) begin
      base_q <= bus.start;
      cnt_q <= 2'h0;
    end else if (bus.step) begin
      cnt_q <= cnt_q + 2'h1; // R15
    end
  end

  // interleaved xors the count in, linear adds it; both wrap at four
  assign bus.addr_lo = (bus.mode == FBS_MODE_INTERLEAVED) ? (base_q ^ cnt_q) : (base_q + cnt_q); // R19 R13

  step_wrap_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (bus.step && !bus.load && cnt_q == FBS_BURST_LAST) |=> cnt_q == 2'h0) // R15
    else $error("burst count did not wrap");
  load_base_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    bus.load |=> bus.addr_lo == $past(bus.start)) // R3
    else $error("loaded address not presented");
endmodule
`default_nettype wire

// ---- verilog/fbs_port.sv ----
// pin-level control of a flow-through burst sram with 36-bit common data bus
// assumes pins synchronous to sys_clk_in; the pad combines out, oe and in
// Function
// R1 - write enable sampled only at qualified edges; low requests a write
// R2 - advance high at qualified edge steps the burst counter
// R3 - advance low at qualified edge loads a new external address
// R4 - controller should load a new address after deselect
// R5 - an edge counts only while clock qualifier is low
// R6 - qualifier high holds all state and does not deselect
// R7 - selected when select one low, select two high, select three low
// R8 - output enable low lets data and parity drive, high floats them
// R9 - outputs float in write data phase, first clock after deselect, deselected
// R10 - read data is the location addressed at the preceding edge
// R11 - data pins feed a register captured at the rising edge
// R12 - parity lanes act as data, each written under its byte select
// R13 - strap high selects interleaved order, low selects linear
// R14 - strap held constant; unconnected strap means interleaved
// R15 - burst covers four accesses on the two low bits, wrapping
// R16 - read or write choice latched at burst start, kept throughout
// R17 - byte select n governs data bits 8n+7 down to 8n
// R18 - controller presents write data for the edge after the command
// R19 - linear adds count modulo four; interleaved xors count with start
// R20 - access only when selected with load; unselected load deselects
`timescale 1ns/100ps
`default_nettype none
module fbs_port
  import fbs_pkg::*;
#(
  parameter int ADDR_W = FBS_ADDR_W
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic clock_qualify_n_in,
  input wire logic write_enable_n_in,
  input wire logic advance_or_load_in,
  input wire logic chip_select_one_n_in,
  input wire logic chip_select_two_in,
  input wire logic chip_select_three_n_in,
  input wire logic output_enable_n_in,
  input wire logic [FBS_LANES-1:0] byte_lane_write_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic burst_mode_in,
  input wire logic burst_mode_valid_in,
  input wire logic [FBS_DATA_W-1:0] data_in,
  input wire logic [FBS_LANES-1:0] parity_lines_in,
  output logic [FBS_DATA_W-1:0] data_out,
  output logic [FBS_LANES-1:0] parity_lines_out,
  output logic data_oe_out
);
  initial begin
    if (ADDR_W < FBS_BURST_W + 1) $error("address too narrow for burst counter");
  end

  localparam int DEPTH = 1 << ADDR_W;

  fbs_burst_if bif();
  fbs_state_t state_q;
  logic edge_ok;
  logic selected;
  logic mode_q;
  logic mode_caught_q;
  logic [ADDR_W-1:0] addr_q;
  logic [FBS_LANES-1:0] lanes_q;
  logic [ADDR_W-1:0] cur_addr;
  logic [FBS_BUS_W-1:0] wr_word_q;
  logic wr_pend_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [FBS_LANES-1:0] wr_lanes_q;
  logic [FBS_BUS_W-1:0] mem_q [DEPTH];
  logic [FBS_BUS_W-1:0] rd_word;
  logic [FBS_BUS_W-1:0] bus_word;

  assign edge_ok = !clock_qualify_n_in; // R5 R6
  assign selected = !chip_select_one_n_in && chip_select_two_in && !chip_select_three_n_in; // R7
  assign cur_addr = {addr_q[ADDR_W-1:FBS_BURST_W], bif.addr_lo};
  assign bus_word = {parity_lines_in, data_in}; // R12

  // strap caught once after reset release, then held
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_q <= FBS_MODE_DEFAULT;
      mode_caught_q <= 1'b0;
    end else if (!mode_caught_q) begin
      mode_caught_q <= 1'b1;
      mode_q <= burst_mode_valid_in ? burst_mode_in : FBS_MODE_DEFAULT; // R14 R13
    end
  end

  assign bif.mode = mode_q;
  assign bif.load = edge_ok && !advance_or_load_in && selected; // R3 R20
  assign bif.step = edge_ok && advance_or_load_in && state_q != FBS_IDLE; // R2
  assign bif.start = addr_in[FBS_BURST_W-1:0];

  fbs_burst_ctr u_ctr (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .bus(bif)
  );

  // access type latched at the load, kept while advancing
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= FBS_IDLE;
      addr_q <= '0;
      lanes_q <= '1;
    end else if (edge_ok) begin
      if (!advance_or_load_in) begin
        if (selected) begin
          addr_q <= addr_in; // R3
          lanes_q <= byte_lane_write_n_in;
          state_q <= write_enable_n_in ? FBS_READ : FBS_WRITE; // R1 R16 R20
        end else begin
          state_q <= FBS_IDLE; // R20
        end
      end else begin
        if (state_q == FBS_WRITE) begin
          lanes_q <= byte_lane_write_n_in;
        end
      end
    end
  end

  // write data arrives at the edge after the command
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_pend_q <= 1'b0;
      wr_word_q <= '0;
      wr_addr_q <= '0;
      wr_lanes_q <= '1;
    end else if (edge_ok) begin
      wr_pend_q <= state_q == FBS_WRITE; // R18
      wr_word_q <= bus_word; // R11
      wr_addr_q <= cur_addr;
      wr_lanes_q <= lanes_q;
    end
  end

  // array write happens at the data edge; storage is plain flip-flops
  always_ff @(posedge sys_clk_in) begin
    if (edge_ok && state_q == FBS_WRITE) begin
      for (int l = 0; l < FBS_LANES; l++) begin
        if (!lanes_q[l]) begin
          mem_q[cur_addr][l*FBS_LANE_W +: FBS_LANE_W] <= data_in[l*FBS_LANE_W +: FBS_LANE_W]; // R17
          mem_q[cur_addr][FBS_DATA_W + l] <= parity_lines_in[l]; // R12
        end
      end
    end
  end

  // flow-through: array read straight out of the storage at the current burst address
  always_comb begin
    rd_word = mem_q[cur_addr]; // R10
  end

  // storage flops muxed straight out; a registered copy would answer a cycle late
  // and collide with the write data that follows a read
  assign data_out = rd_word[FBS_DATA_W-1:0]; // R10
  assign parity_lines_out = rd_word[FBS_BUS_W-1:FBS_DATA_W]; // R12

  assign data_oe_out = (state_q == FBS_READ) && !output_enable_n_in; // R8 R9

  hold_state_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    clock_qualify_n_in |=> $stable(state_q) && $stable(addr_q)) // R6
    else $error("state moved while clock disqualified");
  write_req_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (edge_ok && selected && !advance_or_load_in && !write_enable_n_in) |=> state_q == FBS_WRITE) // R1
    else $error("write request not taken");
  desel_load_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (edge_ok && !selected && !advance_or_load_in) |=> state_q == FBS_IDLE) // R20
    else $error("unselected load did not deselect");
  type_kept_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (edge_ok && advance_or_load_in) |=> state_q == $past(state_q)) // R16
    else $error("access type changed in burst");
  oe_mask_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    output_enable_n_in |-> !data_oe_out) // R8
    else $error("drove with output enable high");
  write_float_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_q == FBS_WRITE) |-> !data_oe_out) // R9
    else $error("drove during write data phase");
  idle_float_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_q == FBS_IDLE) |-> !data_oe_out) // R9
    else $error("drove while deselected");
  data_reg_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (wr_pend_q && !wr_lanes_q[0]) |-> mem_q[wr_addr_q][FBS_LANE_W-1:0] == wr_word_q[FBS_LANE_W-1:0]) // R11
    else $error("captured write data not stored");
  addr_load_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    bif.load |=> addr_q == $past(addr_in)) // R3
    else $error("address not loaded");

  read_c: cover property (@(posedge sys_clk_in) state_q == FBS_READ ##1 data_oe_out);
  write_c: cover property (@(posedge sys_clk_in) state_q == FBS_WRITE ##1 wr_pend_q);
  burst_c: cover property (@(posedge sys_clk_in) bif.load ##1 bif.step [*3]);
  stall_c: cover property (@(posedge sys_clk_in) state_q == FBS_READ && clock_qualify_n_in);
endmodule
`default_nettype wire

// ---- test/fbs_pad_model.sv ----
// controller side of the common 36-bit data bus
// assumes the bench says when write data is due on the pins
`timescale 1ns/100ps
`default_nettype none
module fbs_pad_model
  import fbs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic drive_in,
  input wire logic [FBS_BUS_W-1:0] wdata_in,
  input wire logic dev_oe_in,
  input wire logic [FBS_BUS_W-1:0] dev_data_in,
  output logic [FBS_BUS_W-1:0] pad_out
);
  logic [FBS_BUS_W-1:0] last_q = '0;
  // released bus shows the inverse of its last value, never a stale match
  always_comb begin
    if (dev_oe_in) begin
      pad_out = dev_data_in;
    end else if (drive_in) begin
      pad_out = wdata_in;
    end else begin
      pad_out = ~last_q;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    last_q <= pad_out;
  end
endmodule
`default_nettype wire

// ---- test/tb_fbs_port.sv ----
// self-checking bench for the flow-through burst sram port
// assumes the pad model closes the data bus loop
`timescale 1ns/100ps
`default_nettype none
module tb_fbs_port;
  import fbs_pkg::*;
  logic clk = 1'b0, rst = 1'b1, cq_n = 1'b0, we_n = 1'b1, adv = 1'b0, oe_n = 1'b0;
  logic [2:0] cs = 3'h3; // {three_n, two, one_n}
  logic [3:0] bl_n = 4'h0;
  logic [FBS_ADDR_W-1:0] addr = '0, base;
  logic mode = 1'b0, mode_v = 1'b1, drv = 1'b0, dev_oe, eff = 1'b0;
  logic [FBS_BUS_W-1:0] wd = '0, pad, rd, t;
  logic [FBS_BUS_W-1:0] mem [int];
  logic [FBS_BUS_W-1:0] expq [$];
  logic [FBS_BUS_W-1:0] dv [4];
  int bad_count = 0, checked = 0;
  always #5 clk = ~clk;
  fbs_port DUT (.sys_clk_in(clk), .rst_in(rst), .clock_qualify_n_in(cq_n), .write_enable_n_in(we_n),
    .advance_or_load_in(adv), .chip_select_one_n_in(cs[0]), .chip_select_two_in(cs[1]),
    .chip_select_three_n_in(cs[2]), .output_enable_n_in(oe_n), .byte_lane_write_n_in(bl_n),
    .addr_in(addr), .burst_mode_in(mode), .burst_mode_valid_in(mode_v), .data_in(pad[31:0]),
    .parity_lines_in(pad[35:32]), .data_out(rd[31:0]), .parity_lines_out(rd[35:32]), .data_oe_out(dev_oe));
  fbs_pad_model partner (.sys_clk_in(clk), .drive_in(drv), .wdata_in(wd), .dev_oe_in(dev_oe),
    .dev_data_in(rd), .pad_out(pad));
  task automatic chk(input logic [FBS_BUS_W-1:0] seen, input logic [FBS_BUS_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("mismatches %0d of %0d checks", bad_count, checked);
    if (bad_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cyc(input logic q, input logic w, input logic a, input logic [2:0] c,
    input logic [FBS_ADDR_W-1:0] ad, input logic d, input logic [FBS_BUS_W-1:0] v);
    @(posedge clk);
    #1;
    cq_n = q;
    we_n = w;
    adv = a;
    cs = c;
    addr = ad;
    drv = d;
    wd = v;
  endtask
  task automatic idle(input int n);
    repeat (n) cyc(1'b0, 1'b1, 1'b0, 3'h3, '0, 1'b0, '0);
  endtask
  function automatic logic [1:0] lo(input logic [1:0] s, input logic [1:0] k);
    return (!mode_v || mode) ? s ^ k : s + k;
  endfunction
  // a frozen edge yields no new result, so only effective edges pull a note
  always @(posedge clk) eff <= !cq_n;
  always @(negedge clk) begin
    if (eff && dev_oe === 1'b1) begin
      if (expq.size() == 0) begin
        chk('0, '1);
      end else begin
        chk(rd, expq.pop_front());
      end
    end
  end
  initial begin
    #100000;
    bad_count++;
    wrap_up;
  end
  initial begin
    int k, m, a;
    k = $urandom(32'h787a);
    for (int p = 0; p < 3; p++) begin
      mode = (p == 1);
      mode_v = (p != 2);
      rst = 1'b1;
      repeat (10) @(posedge clk);
      #1;
      rst = 1'b0;
      repeat (2) @(posedge clk);
      base = FBS_ADDR_W'($urandom());
      for (k = 0; k < 4; k++) dv[k] = {4'($urandom()), $urandom()};
      cyc(1'b0, 1'b0, 1'b0, 3'h2, base, 1'b0, '0);
      cyc(1'b0, 1'b1, 1'b1, 3'h2, '0, 1'b1, dv[0]);
      cyc(1'b1, 1'b0, 1'b0, 3'h2, FBS_ADDR_W'($urandom()), 1'b1, '1);
      cyc(1'b0, 1'b0, 1'b1, 3'h5, '0, 1'b1, dv[1]);
      cyc(1'b0, 1'b1, 1'b1, 3'h2, '0, 1'b1, dv[2]);
      cyc(1'b0, 1'b1, 1'b0, 3'h3, '0, 1'b1, dv[3]);
      for (k = 0; k < 4; k++) mem[int'({base[16:2], lo(base[1:0], 2'(k))})] = dv[k];
      for (k = 0; k < 4; k++) begin
        cyc(1'b0, 1'b1, 1'b0, 3'h2, {base[16:2], 2'(k)}, 1'b0, '0);
        expq.push_back(mem[int'({base[16:2], 2'(k)})]);
      end
      for (k = 0; k < 4; k++) begin
        if (k == 2) cyc(1'b1, 1'b0, 1'b0, 3'h2, FBS_ADDR_W'($urandom()), 1'b0, '0);
        cyc(1'b0, ~k[0], k != 0, 3'h2, base, 1'b0, '0);
        expq.push_back(mem[int'({base[16:2], lo(base[1:0], 2'(k))})]);
      end
      m = $urandom_range(15);
      a = int'({base[16:2], 2'h0});
      dv[0] = {4'($urandom()), $urandom()};
      bl_n = 4'(m);
      cyc(1'b0, 1'b0, 1'b0, 3'h2, base & ~17'h3, 1'b0, '0);
      cyc(1'b0, 1'b1, 1'b0, 3'h3, '0, 1'b1, dv[0]);
      bl_n = 4'h0;
      t = mem[a];
      for (k = 0; k < 4; k++) begin
        if (!m[k]) begin
          t[8*k +: 8] = dv[0][8*k +: 8];
          t[32+k] = dv[0][32+k];
        end
      end
      mem[a] = t;
      for (k = 0; k < 3; k++) begin
        cyc(1'b0, 1'b0, 1'b0, 3'h2 ^ 3'(1 << k), base & ~17'h3, 1'b0, '0);
        cyc(1'b0, 1'b1, 1'b0, 3'h2 ^ 3'(1 << k), base & ~17'h3, 1'b1, ~t);
      end
      cyc(1'b0, 1'b1, 1'b0, 3'h2, base & ~17'h3, 1'b0, '0);
      expq.push_back(t);
      idle(4);
      oe_n = 1'b1;
      cyc(1'b0, 1'b1, 1'b0, 3'h2, base & ~17'h3, 1'b0, '0);
      idle(1);
      chk(FBS_BUS_W'(dev_oe), '0);
      idle(4);
      oe_n = 1'b0;
    end
    idle(3);
    chk(FBS_BUS_W'(expq.size()), '0);
    wrap_up;
  end
endmodule
`default_nettype wire
